// file: design/tpe_pkg.sv
/*
  Shared constants and types of the timer prescaler and edge control block.
  Assumes a 200 MHz core clock and an APB slave with 32-bit data words.
*/
package tpe_pkg;

  // Register indices; a byte address is four times the index.
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h05;
  localparam logic [7:0] IDX_INT_STATUS_ENABLE = 8'h07;
  localparam logic [7:0] IDX_TIMER_COUNT_LOW = 8'h0b;
  localparam logic [7:0] IDX_TIMER_COUNT_HIGH = 8'h0c;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;

  // Field positions of timer_control.
  localparam int CTL_IRQ_EDGE_BIT = 7;
  localparam int CTL_EXT_EDGE_BIT = 6;
  localparam int CTL_SRC_BIT = 5;
  localparam int CTL_PS_HI = 4;
  localparam int CTL_PS_LO = 1;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hfe;

  // Field positions of interrupt_status_enable.
  localparam int INT_PERIPH_FLAG_BIT = 7;
  localparam int INT_EXT_CLK_FLAG_BIT = 6;
  localparam int INT_OVF_FLAG_BIT = 5;
  localparam int INT_EXT_IRQ_FLAG_BIT = 4;

  // Field positions of irq_status and irq_mask.
  localparam int IST_EXT_IRQ_BIT = 0;
  localparam int IST_EXT_CLK_BIT = 1;
  localparam int IST_OVF_BIT = 2;
  localparam int IST_WIDTH = 3;

  // Values after reset.
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] INTSE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [IST_WIDTH-1:0] IST_RESET = 3'h0;
  localparam logic [7:0] PRESC_RESET = 8'h00;

  // Instruction cycle derived from the core clock.
  localparam int CORE_PERIOD_NS = 5;
  localparam int INSTR_PERIOD_NS = 20;
  localparam int INSTR_DIV_CYCLES = INSTR_PERIOD_NS / CORE_PERIOD_NS;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV_CYCLES - 1);

  // APB answer sequencing.
  typedef enum logic [1:0] {
    TPE_IDLE,
    TPE_ACK
  } tpe_apb_state_t;

endpackage

// file: design/tpe_edge_sync.sv
/*
  Two-stage synchroniser with rising and falling edge detection for one pin.
  Assumes the pin is asynchronous to pclk and slower than half its rate.
*/
`timescale 1ns/100ps
`default_nettype none
module tpe_edge_sync
  import tpe_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic sync;
  logic prev;

  // The first stage feeds only the second; the edge logic reads later stages.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edges are one-cycle pulses on the synchronised level.
  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule
`default_nettype wire

// file: design/tpe_prescaler.sv
/*
  Power-of-two prescaler from 1:1 to 1:256 for the timer tick.
  Assumes tick_in is a one-cycle pulse on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module tpe_prescaler
  import tpe_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [3:0] sel,
  output logic tick_out
);

  logic [7:0] cnt;
  logic [7:0] mask;

  // Codes 0 to 7 give 2**code, any code with the top bit set gives 256.
  always_comb begin
    if (sel[3]) begin
      mask = 8'hff;
    end else begin
      mask = 8'((9'h001 << sel[2:0]) - 9'h001);
    end
  end

  // The counter runs freely on input ticks and restarts when the timer is loaded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= PRESC_RESET;
    end else if (clear) begin
      cnt <= PRESC_RESET;
    end else if (tick_in) begin
      cnt <= cnt + 8'h01;
    end
  end

  // An output tick leaves when all selected low bits are ones.
  assign tick_out = tick_in & ~clear & ((cnt & mask) == mask);

  AST_PS_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
    (sel == 4'h0 && tick_in && !clear) |-> tick_out)
    else $error("Prescaler 1:1 dropped a tick.");

  AST_PS_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    (sel[3] && tick_out) |-> (cnt == 8'hff))
    else $error("Prescaler 1:256 ticked early.");

endmodule
`default_nettype wire

// file: design/tpe_timer0.sv
/*
  Timer0 control block: timer_control, interrupt_status_enable, the 16-bit
  timer_count and an interrupt unit, all reached over APB.
  Assumes a 200 MHz pclk, an APB master obeying the protocol and two
  asynchronous pins for the external clock and external interrupt.
*/
`timescale 1ns/100ps
`default_nettype none
module tpe_timer0
  import tpe_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_ext_clock_pin,
  input wire logic ext_irq_pin,
  output logic irq
);

  tpe_apb_state_t state;
  tpe_apb_state_t next_state;
  logic [7:0] timer_control;
  logic [7:0] interrupt_status_enable;
  logic [15:0] timer_count;
  logic [IST_WIDTH-1:0] irq_status;
  logic [IST_WIDTH-1:0] irq_mask;
  logic [1:0] instr_div;
  logic instr_tick;
  logic irq_level;
  logic irq_rise;
  logic irq_fall;
  logic clk_level;
  logic clk_rise;
  logic clk_fall;
  logic ext_irq_evt;
  logic ext_clk_evt;
  logic src_tick;
  logic count_tick;
  logic ovf_evt;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [7:0] idx;
  logic aligned;
  logic hit_ctl;
  logic hit_intse;
  logic hit_low;
  logic hit_high;
  logic hit_ist;
  logic hit_mask;
  logic mapped;
  logic count_write;
  logic [7:0] next_rdata;
  logic [IST_WIDTH-1:0] ist_set;
  logic [IST_WIDTH-1:0] ist_kept;

  // Address decode: word aligned, index in bits 9 to 2, upper bits zero.
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign hit_ctl = aligned && (idx == IDX_TIMER_CONTROL);
  assign hit_intse = aligned && (idx == IDX_INT_STATUS_ENABLE);
  assign hit_low = aligned && (idx == IDX_TIMER_COUNT_LOW);
  assign hit_high = aligned && (idx == IDX_TIMER_COUNT_HIGH);
  assign hit_ist = aligned && (idx == IDX_IRQ_STATUS);
  assign hit_mask = aligned && (idx == IDX_IRQ_MASK);
  assign mapped = hit_ctl | hit_intse | hit_low | hit_high | hit_ist | hit_mask;

  // A transfer completes at the edge where pready is seen high in the access phase.
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite && mapped;
  assign rd_done = done && !pwrite && mapped;

  // The slave answers one cycle into the access phase.
  always_comb begin
    case (state)
      TPE_IDLE: begin
        if (psel && penable) begin
          next_state = TPE_ACK;
        end else begin
          next_state = TPE_IDLE;
        end
      end
      TPE_ACK: begin
        next_state = TPE_IDLE;
      end
      default: begin
        next_state = TPE_IDLE;
      end
    endcase
  end

  // State register of the bus answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TPE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Read data selection; unmapped words and unimplemented bits read as zero.
  always_comb begin
    next_rdata = 8'h00;
    if (hit_ctl) begin
      next_rdata = timer_control & CTL_WRITE_MASK;
    end else if (hit_intse) begin
      next_rdata = interrupt_status_enable;
    end else if (hit_low) begin
      next_rdata = timer_count[7:0];
    end else if (hit_high) begin
      next_rdata = timer_count[15:8];
    end else if (hit_ist) begin
      next_rdata = {5'h00, irq_status};
    end else if (hit_mask) begin
      next_rdata = {5'h00, irq_mask};
    end
  end

  // Bus outputs are registered with the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (next_state == TPE_ACK) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= (!pwrite) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // Configuration register; bit 0 is unimplemented and holds zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control <= CTL_RESET;
    end else if (wr_done && hit_ctl) begin
      timer_control <= pwdata[7:0] & CTL_WRITE_MASK;
    end
  end

  // Synchronisers and edge detectors for both pins.
  tpe_edge_sync u_irq_pin (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_irq_pin),
    .level(irq_level),
    .rise(irq_rise),
    .fall(irq_fall)
  );

  tpe_edge_sync u_clk_pin (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_ext_clock_pin),
    .level(clk_level),
    .rise(clk_rise),
    .fall(clk_fall)
  );

  // Edge selection for the interrupt pin and the clock pin.
  assign ext_irq_evt = timer_control[CTL_IRQ_EDGE_BIT] ? irq_rise : irq_fall;
  assign ext_clk_evt = timer_control[CTL_EXT_EDGE_BIT] ? clk_rise : clk_fall;

  // Instruction cycle enable: one pulse every four core cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'b00;
    end else if (instr_div == INSTR_DIV_LAST) begin
      instr_div <= 2'b00;
    end else begin
      instr_div <= instr_div + 2'b01;
    end
  end
  assign instr_tick = (instr_div == INSTR_DIV_LAST);

  // Clock source choice; the edge select bit has no effect on the internal path.
  assign src_tick = timer_control[CTL_SRC_BIT] ? instr_tick : ext_clk_evt;

  // Loading either count byte restarts the prescaler so the new value lasts a full period.
  assign count_write = wr_done && (hit_low || hit_high);

  tpe_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(count_write),
    .tick_in(src_tick),
    .sel(timer_control[CTL_PS_HI:CTL_PS_LO]),
    .tick_out(count_tick)
  );

  // The 16-bit count: software byte writes win over a tick in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= COUNT_RESET;
    end else if (wr_done && hit_low) begin
      timer_count[7:0] <= pwdata[7:0];
    end else if (wr_done && hit_high) begin
      timer_count[15:8] <= pwdata[7:0];
    end else if (count_tick) begin
      timer_count <= timer_count + 16'h0001;
    end
  end
  assign ovf_evt = count_tick && !count_write && (timer_count == 16'hffff);

  // Flags and enables; a hardware event in the cycle of a clearing write still sets its flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_status_enable <= INTSE_RESET;
    end else begin
      if (wr_done && hit_intse) begin
        interrupt_status_enable <= pwdata[7:0];
      end
      if (ext_irq_evt) begin
        interrupt_status_enable[INT_EXT_IRQ_FLAG_BIT] <= 1'b1;
      end
      if (ext_clk_evt) begin
        interrupt_status_enable[INT_EXT_CLK_FLAG_BIT] <= 1'b1;
      end
      if (ovf_evt) begin
        interrupt_status_enable[INT_OVF_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Sticky status events.
  always_comb begin
    ist_set = IST_RESET;
    ist_set[IST_EXT_IRQ_BIT] = ext_irq_evt;
    ist_set[IST_EXT_CLK_BIT] = ext_clk_evt;
    ist_set[IST_OVF_BIT] = ovf_evt;
  end

  // A read clears only the bits that its answer reported; an event that lands while the
  // answer stands would otherwise be lost without ever being seen by software.
  assign ist_kept = irq_status & ~prdata[IST_WIDTH-1:0];

  // Status clears on read, and a new event in the read cycle survives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= IST_RESET;
    end else if (rd_done && hit_ist) begin
      irq_status <= ist_kept | ist_set;
    end else begin
      irq_status <= irq_status | ist_set;
    end
  end

  // Mask register of the same layout as the status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= IST_RESET;
    end else if (wr_done && hit_mask) begin
      irq_mask <= pwdata[IST_WIDTH-1:0];
    end
  end

  // Level interrupt output, registered from the next status and mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (wr_done && hit_mask) begin
      irq <= |((irq_status | ist_set) & pwdata[IST_WIDTH-1:0]);
    end else if (rd_done && hit_ist) begin
      irq <= |((ist_kept | ist_set) & irq_mask);
    end else begin
      irq <= |((irq_status | ist_set) & irq_mask);
    end
  end

  // Named steps of a bus transfer and of a pin edge.
  sequence seq_setup;
    psel && !penable;
  endsequence

  sequence seq_access;
    psel && penable;
  endsequence

  sequence seq_irq_rise;
    timer_control[CTL_IRQ_EDGE_BIT] && $rose(irq_level);
  endsequence

  sequence seq_irq_fall;
    !timer_control[CTL_IRQ_EDGE_BIT] && $fell(irq_level);
  endsequence

  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    seq_setup ##1 seq_access |=> pready)
    else $error("APB answer did not come one cycle into the access phase.");

  AST_IRQ_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    seq_irq_rise |=> interrupt_status_enable[INT_EXT_IRQ_FLAG_BIT])
    else $error("Rising interrupt pin edge did not set the flag.");

  AST_IRQ_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    seq_irq_fall |=> interrupt_status_enable[INT_EXT_IRQ_FLAG_BIT])
    else $error("Falling interrupt pin edge did not set the flag.");

  AST_IRQ_WRONG_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_control[CTL_IRQ_EDGE_BIT] && $rose(irq_level)) |-> !ext_irq_evt)
    else $error("Unselected interrupt pin edge was taken.");

  AST_CLK_EDGE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control[CTL_EXT_EDGE_BIT] && $rose(clk_level)) |=>
      interrupt_status_enable[INT_EXT_CLK_FLAG_BIT])
    else $error("Selected clock pin edge did not set its flag.");

  AST_EXT_SRC_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_control[CTL_SRC_BIT] && !timer_control[CTL_EXT_EDGE_BIT] && $fell(clk_level))
      |-> src_tick)
    else $error("Falling clock pin edge did not reach the prescaler.");

  AST_INT_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control[CTL_SRC_BIT] && !instr_tick) |-> !src_tick)
    else $error("Internal source ticked outside the instruction cycle.");

  AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (count_tick && !count_write) |=> (timer_count == $past(timer_count) + 16'h0001))
    else $error("Timer count did not step by one on a tick.");

  AST_OVF_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_evt |=> (timer_count == 16'h0000) && interrupt_status_enable[INT_OVF_FLAG_BIT]
      && irq_status[IST_OVF_BIT])
    else $error("Overflow did not wrap and flag.");

endmodule
`default_nettype wire

// file: testbench/tpe_pin_model.sv
/*
  Model of the two pins beside the timer block: external clock and interrupt.
  Assumes one bench process calls its tasks and pclk runs free.
*/
`timescale 1ns/100ps
`default_nettype none
module tpe_pin_model (
  input wire logic pclk,
  output logic timer_ext_clock_pin,
  output logic ext_irq_pin
);
  // Both pins rest low until the bench moves them.
  initial begin
    timer_ext_clock_pin = 1'b0;
    ext_irq_pin = 1'b0;
  end

  // Each level is held five cycles so the synchroniser cannot miss it.
  task automatic set_clk(input logic v);
    @(posedge pclk);
    timer_ext_clock_pin <= v;
    repeat (4) @(posedge pclk);
  endtask

  // Sends whole pulses, so each pulse has one rising and one falling edge.
  task automatic pulses(input int n);
    repeat (n) begin
      set_clk(1'b1);
      set_clk(1'b0);
    end
  endtask

  // Moves the interrupt pin and holds it the same way.
  task automatic set_irq(input logic v);
    @(posedge pclk);
    ext_irq_pin <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// file: testbench/tpe_timer0_tb_top.sv
/*
  Self-checking bench of the timer block: APB master, pin model, random prescale runs.
  Assumes the design answers APB with one wait cycle and syncs pins in two flops.
*/
`timescale 1ns/100ps
`default_nettype none
module tpe_timer0_tb_top;
  import tpe_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rd;
  logic [3:0] addr_junk;
  wire logic clk_pin;
  wire logic irq_pin;
  int n_fail, samples_checked, cyc;

  tpe_timer0 dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ext_clock_pin(clk_pin), .ext_irq_pin(irq_pin), .irq(irq));
  tpe_pin_model pin_u (.pclk(pclk), .timer_ext_clock_pin(clk_pin), .ext_irq_pin(irq_pin));

  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compares one value and counts the result.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {addr_junk[3:2], idx, addr_junk[1:0]};
    pwdata <= {24'($urandom), wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The count is moved as two separate bytes.
  task automatic read_count(output logic [15:0] v);
    apb(1'b0, IDX_TIMER_COUNT_LOW, 8'h00);
    v[7:0] = rd;
    apb(1'b0, IDX_TIMER_COUNT_HIGH, 8'h00);
    v[15:8] = rd;
  endtask

  task automatic write_count(input logic [15:0] v);
    apb(1'b1, IDX_TIMER_COUNT_LOW, v[7:0]);
    apb(1'b1, IDX_TIMER_COUNT_HIGH, v[15:8]);
  endtask

  // Expected count after p selected edges at a given prescale code.
  function automatic logic [15:0] exp_count(input int p, input logic [3:0] code);
    return code[3] ? 16'(p >> 8) : 16'(p >> code[2:0]);
  endfunction

  function automatic logic [7:0] ctl(input logic ie, input logic ee, input logic src,
    input logic [3:0] code);
    return {ie, ee, src, code, 1'b0};
  endfunction

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well above the expected run length.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      $display("Error timeout expected finish got stall");
      summarize();
    end
  end

  initial begin
    logic [15:0] v;
    logic [3:0] code;
    logic ee;
    int p;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    addr_junk = 4'h0;
    presetn = 1'b0;
    void'($urandom(32'h93d6));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, the read-only bit and an unmapped place.
    apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
    check("ctl_reset", CTL_RESET, rd);
    apb(1'b0, IDX_INT_STATUS_ENABLE, 8'h00);
    check("intse_reset", INTSE_RESET, rd);
    read_count(v);
    check("count_reset", COUNT_RESET, v);
    apb(1'b1, IDX_TIMER_CONTROL, 8'hff);
    apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
    check("ctl_rw", 8'hfe, rd);
    apb(1'b1, IDX_INT_STATUS_ENABLE, 8'h0f);
    apb(1'b0, IDX_INT_STATUS_ENABLE, 8'h00);
    check("intse_rw", 8'h0f, rd);
    apb(1'b0, 8'h20, 8'h00);
    check("unmapped_err", 1'b1, err);
    check("unmapped_data", 8'h00, rd);
    // Misaligned and out-of-range addresses are refused and leave the register alone.
    addr_junk = 4'h2;
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    check("misaligned_err", 1'b1, err);
    addr_junk = 4'h8;
    apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
    check("high_addr_err", 1'b1, err);
    check("high_addr_data", 8'h00, rd);
    addr_junk = 4'h0;
    apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
    check("ctl_kept", 8'hfe, rd);
    $display("test registers done");
    // Interrupt pin: the unselected edge first, then the selected one.
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, IDX_TIMER_CONTROL, ctl(e[0], 1'b0, 1'b0, 4'h0));
      pin_u.set_irq(e[0]);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      pin_u.set_irq(~e[0]);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      check("irq_wrong_edge", 1'b0, rd[IST_EXT_IRQ_BIT]);
      apb(1'b1, IDX_INT_STATUS_ENABLE, 8'h00);
      pin_u.set_irq(e[0]);
      apb(1'b0, IDX_INT_STATUS_ENABLE, 8'h00);
      check("ext_irq_flag", 1'b1, rd[INT_EXT_IRQ_FLAG_BIT]);
      apb(1'b1, IDX_INT_STATUS_ENABLE, 8'h00);
      apb(1'b0, IDX_IRQ_STATUS, 8'h00);
      check("irq_edge", 1'b1, rd[IST_EXT_IRQ_BIT]);
    end
    $display("test interrupt edge done");
    // Clock pin edge choice: only the selected edge advances the count.
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, IDX_TIMER_CONTROL, ctl(1'b0, e[0], 1'b0, 4'h0));
      write_count(16'h0000);
      pin_u.set_clk(1'b1);
      read_count(v);
      check("cnt_after_rise", {15'h0000, e[0]}, v);
      pin_u.set_clk(1'b0);
      read_count(v);
      check("cnt_after_fall", 16'h0001, v);
    end
    $display("test clock edge done");
    // Internal source: one step per 4 pclk, while pin edges only raise the flag.
    apb(1'b1, IDX_TIMER_CONTROL, ctl(1'b0, 1'b1, 1'b1, 4'h0));
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    write_count(16'h0000);
    pin_u.pulses(1);
    repeat (380) @(posedge pclk);
    read_count(v);
    check("internal_rate", 1'b1, v >= 16'd95 && v <= 16'd101);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    check("clk_flag_internal", 1'b1, rd[IST_EXT_CLK_BIT]);
    $display("test internal source done");
    // Prescale codes: boundary cases first, then random codes and counts.
    for (int i = 0; i < 8; i++) begin
      code = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : (i == 2) ? 4'hf : 4'($urandom_range(15));
      p = (i < 2) ? 255 : (i == 2) ? 256 : int'($urandom_range(400, 1));
      ee = 1'($urandom_range(1));
      apb(1'b1, IDX_TIMER_CONTROL, ctl(1'b0, ee, 1'b0, code));
      write_count(16'h0000);
      pin_u.pulses(p);
      read_count(v);
      check("presc_count", exp_count(p, code), v);
    end
    $display("test prescale done");
    // Byte carry, wrap to zero and the masked overflow interrupt.
    apb(1'b1, IDX_TIMER_CONTROL, ctl(1'b0, 1'b1, 1'b0, 4'h0));
    write_count(16'h12fe);
    pin_u.pulses(3);
    read_count(v);
    check("carry", 16'h1301, v);
    write_count(16'hffff);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    apb(1'b1, IDX_IRQ_MASK, 8'h04);
    @(negedge pclk);
    check("irq_idle", 1'b0, irq);
    pin_u.pulses(1);
    @(negedge pclk);
    check("irq_ovf", 1'b1, irq);
    read_count(v);
    check("wrap", 16'h0000, v);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    check("status_ovf", 8'h06, rd);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("irq_cleared", 1'b0, irq);
    pin_u.pulses(1);
    @(negedge pclk);
    check("irq_masked", 1'b0, irq);
    $display("test overflow done");
    summarize();
  end
endmodule
`default_nettype wire
